// file: rtl/ccu_consts.vh
// Shared constants of the code conversion unit.
// How it works
// RULE1: Each hex digit becomes one ASCII character code.
// RULE2: Program stacks count, accumulator holds source start.
// RULE3: Digits 0-9 map 30h-39h, A-F 41h-46h.
// RULE4: Segment converts four accumulator digits to patterns.
// RULE5: Pattern byte: bits 0-6 segments a-g.
// RULE6: Gray converts to BCD and clears upper bits.
// RULE7: 512 and 1024 count encoders need no correction.
// RULE8: Program corrects 360 and 720 count encoders.
// RULE9: Shuffle reorders eight stack digits into accumulator.
// RULE10: Order digit position matches source digit position.
// RULE11: Order digit k places source at position k.
// RULE12: Order digit 0 or 9-F contributes zero.
// RULE13: Most significant duplicate order digit wins.
// RULE14: Accumulator is 32 bits, all usable.
`ifndef CCU_CONSTS_VH
`define CCU_CONSTS_VH

// ----------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------
`define CCU_OP_HEX_TO_ASCII 2'h0
`define CCU_OP_SEGMENT 2'h1
`define CCU_OP_GRAY 2'h2
`define CCU_OP_DIGIT_REORDER 2'h3

// ----------------------------------------------------------------------
// Widths, fields and reset values
// ----------------------------------------------------------------------
`define CCU_ACC_W 32
`define CCU_ACC_RESET 32'h0000_0000
`define CCU_WORD_RESET 16'h0000
`define CCU_GRAY_BIN_W 10
`define CCU_GRAY_BCD_W 16
`define CCU_ASCII_NUM_BASE 8'h30
`define CCU_ASCII_ALPHA_BASE 8'h37
`define CCU_DIGIT_TEN 4'hA
`define CCU_ORDER_MIN 4'h1
`define CCU_ORDER_MAX 4'h8

`endif

// file: rtl/ccu_seg_rom.v
// Seven-segment pattern lookup for one hex digit.
`timescale 1ns/1ns
`default_nettype none

module ccu_seg_rom (
   input wire [3:0] digit_in,
   output reg [6:0] pattern_out
);

   // Bit 0 drives segment a up to bit 6 for segment g; high means lit.
   always @* begin
      case (digit_in)
         4'h0: pattern_out = 7'h3F;
         4'h1: pattern_out = 7'h06;
         4'h2: pattern_out = 7'h5B;
         4'h3: pattern_out = 7'h4F;
         4'h4: pattern_out = 7'h66;
         4'h5: pattern_out = 7'h6D;
         4'h6: pattern_out = 7'h7D;
         4'h7: pattern_out = 7'h07;
         4'h8: pattern_out = 7'h7F;
         4'h9: pattern_out = 7'h6F;
         4'hA: pattern_out = 7'h77;
         4'hB: pattern_out = 7'h7C;
         4'hC: pattern_out = 7'h39;
         4'hD: pattern_out = 7'h5E;
         4'hE: pattern_out = 7'h79;
         default: pattern_out = 7'h71;
      endcase
   end

endmodule

`default_nettype wire

// file: rtl/ccu_top.v
// Conversion datapath: hex to ASCII, segment, Gray to BCD, digit reorder.
`timescale 1ns/1ns
`default_nettype none
`include "ccu_consts.vh"

module ccu_top #(
   parameter ADDR_W = 16
) (
   input wire SYS_CLK_IN,
   input wire SRST_IN,
   input wire CE_IN,
   input wire START_IN,
   input wire [1:0] OP_IN,
   input wire [31:0] ACC_IN,
   input wire [31:0] STACK1_IN,
   input wire [ADDR_W-1:0] DEST_IN,
   input wire [15:0] MEM_RDATA_IN,
   output reg [31:0] ACC_OUT,
   output reg DONE_OUT,
   output reg BUSY_OUT,
   output reg MEM_RD_OUT,
   output reg MEM_WR_OUT,
   output reg [ADDR_W-1:0] MEM_ADDR_OUT,
   output reg [15:0] MEM_WDATA_OUT
);

   // ----------------------------------------------------------------------
   // States of the table sequencer
   // ----------------------------------------------------------------------
   localparam ST_IDLE = 3'h0;
   localparam ST_WAIT = 3'h1;
   localparam ST_CAP = 3'h2;
   localparam ST_WR2 = 3'h3;
   localparam ST_NEXT = 3'h4;

   reg [2:0] state;
   reg [15:0] count;
   reg [ADDR_W-1:0] src_addr;
   reg [ADDR_W-1:0] dst_addr;
   reg [7:0] low_digits;

   wire [6:0] seg_pat [0:3];
   reg [31:0] seg_result;
   reg [31:0] gray_result;
   reg [31:0] reorder_result;
   reg [31:0] next_acc;

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------

   // One hex digit to its ASCII character code.
   function [7:0] to_ascii;
      input [3:0] d;
      begin
         if (d < `CCU_DIGIT_TEN) begin
            to_ascii = `CCU_ASCII_NUM_BASE + {4'h0, d}; // RULE3
         end else begin
            to_ascii = `CCU_ASCII_ALPHA_BASE + {4'h0, d}; // RULE3
         end
      end
   endfunction

   // Double dabble of a ten-bit count into four BCD digits.
   function [15:0] to_bcd;
      input [9:0] bin;
      integer i;
      reg [25:0] sh;
      begin
         sh = {16'h0000, bin};
         for (i = 0; i < 10; i = i + 1) begin
            if (sh[13:10] > 4'h4) begin
               sh[13:10] = sh[13:10] + 4'h3;
            end
            if (sh[17:14] > 4'h4) begin
               sh[17:14] = sh[17:14] + 4'h3;
            end
            if (sh[21:18] > 4'h4) begin
               sh[21:18] = sh[21:18] + 4'h3;
            end
            if (sh[25:22] > 4'h4) begin
               sh[25:22] = sh[25:22] + 4'h3;
            end
            sh = {sh[24:0], 1'b0};
         end
         to_bcd = sh[25:10];
      end
   endfunction

   // ----------------------------------------------------------------------
   // Segment conversion
   // ----------------------------------------------------------------------

   // Four lookups, one per accumulator digit of the low half.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : seg_digit
         ccu_seg_rom u_rom (
            .digit_in(ACC_IN[4*g+3:4*g]),
            .pattern_out(seg_pat[g])
         );
      end
   endgenerate

   // Each pattern takes one byte with its top bit clear.
   always @* begin
      seg_result = {1'b0, seg_pat[3], 1'b0, seg_pat[2],
                    1'b0, seg_pat[1], 1'b0, seg_pat[0]}; // RULE4 RULE5
   end

   // ----------------------------------------------------------------------
   // Gray code conversion
   // ----------------------------------------------------------------------

   // A plain reflected Gray decode gives the true count for 512 and 1024
   // step encoders; other resolutions are corrected by the program.
   always @* begin : gray_blk
      integer i;
      reg [15:0] bin;
      bin = 16'h0000;
      bin[15] = ACC_IN[15];
      for (i = 14; i >= 0; i = i - 1) begin
         bin[i] = bin[i+1] ^ ACC_IN[i]; // RULE7
      end
      gray_result = {16'h0000,
                     to_bcd(bin[`CCU_GRAY_BIN_W-1:0])}; // RULE6
   end

   // ----------------------------------------------------------------------
   // Digit reorder
   // ----------------------------------------------------------------------

   // Ascending scan lets a more significant duplicate overwrite a lower
   // one, and positions nobody selects stay zero.
   always @* begin : reorder_blk
      integer i;
      reg [3:0] ord;
      reg [2:0] pos;
      reorder_result = `CCU_ACC_RESET;
      ord = 4'h0;
      pos = 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
         ord = ACC_IN[4*i +: 4]; // RULE10
         pos = ord[2:0] - 3'h1;
         if (ord >= `CCU_ORDER_MIN && ord <= `CCU_ORDER_MAX) begin // RULE12
            reorder_result[4*pos +: 4] = STACK1_IN[4*i +: 4]; // RULE11 RULE13
         end
      end
   end

   // Result chosen by operation for the single-step instructions.
   always @* begin
      if (OP_IN == `CCU_OP_SEGMENT) begin
         next_acc = seg_result;
      end else if (OP_IN == `CCU_OP_GRAY) begin
         next_acc = gray_result;
      end else if (OP_IN == `CCU_OP_DIGIT_REORDER) begin
         next_acc = reorder_result; // RULE9
      end else begin
         next_acc = ACC_IN; // RULE14
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer and output registers
   // ----------------------------------------------------------------------

   // Single-step operations finish one edge after START_IN. The table
   // operation reads a word, then writes two words; memory returns read
   // data in the cycle after MEM_RD_OUT was high. Starts while busy are
   // ignored, since the operands are no longer stable.
   always @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         state <= ST_IDLE;
         count <= `CCU_WORD_RESET;
         src_addr <= {ADDR_W{1'b0}};
         dst_addr <= {ADDR_W{1'b0}};
         low_digits <= 8'h00;
         ACC_OUT <= `CCU_ACC_RESET;
         DONE_OUT <= 1'b0;
         BUSY_OUT <= 1'b0;
         MEM_RD_OUT <= 1'b0;
         MEM_WR_OUT <= 1'b0;
         MEM_ADDR_OUT <= {ADDR_W{1'b0}};
         MEM_WDATA_OUT <= `CCU_WORD_RESET;
      end else if (CE_IN) begin
         DONE_OUT <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (START_IN) begin
                  ACC_OUT <= next_acc;
                  if (OP_IN == `CCU_OP_HEX_TO_ASCII) begin
                     // Count comes from the stack, source from the
                     // accumulator, destination from the operand.
                     count <= STACK1_IN[15:0]; // RULE2
                     src_addr <= ACC_IN[ADDR_W-1:0] +
                        {{(ADDR_W-1){1'b0}}, 1'b1};
                     dst_addr <= DEST_IN;
                     MEM_ADDR_OUT <= ACC_IN[ADDR_W-1:0];
                     if (STACK1_IN[15:0] == 16'h0000) begin
                        DONE_OUT <= 1'b1;
                     end else begin
                        MEM_RD_OUT <= 1'b1;
                        BUSY_OUT <= 1'b1;
                        state <= ST_WAIT;
                     end
                  end else begin
                     DONE_OUT <= 1'b1;
                  end
               end
            end
            ST_WAIT: begin
               MEM_RD_OUT <= 1'b0;
               state <= ST_CAP;
            end
            ST_CAP: begin
               // Upper two digits go to the first destination word.
               MEM_WR_OUT <= 1'b1;
               MEM_ADDR_OUT <= dst_addr;
               MEM_WDATA_OUT <= {to_ascii(MEM_RDATA_IN[15:12]),
                                 to_ascii(MEM_RDATA_IN[11:8])}; // RULE1
               low_digits <= MEM_RDATA_IN[7:0];
               state <= ST_WR2;
            end
            ST_WR2: begin
               MEM_ADDR_OUT <= dst_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
               MEM_WDATA_OUT <= {to_ascii(low_digits[7:4]),
                                 to_ascii(low_digits[3:0])}; // RULE1
               dst_addr <= dst_addr + {{(ADDR_W-2){1'b0}}, 2'h2};
               count <= count - 16'h0001;
               state <= ST_NEXT;
            end
            ST_NEXT: begin
               MEM_WR_OUT <= 1'b0;
               if (count == 16'h0000) begin
                  BUSY_OUT <= 1'b0;
                  DONE_OUT <= 1'b1;
                  state <= ST_IDLE;
               end else begin
                  MEM_RD_OUT <= 1'b1;
                  MEM_ADDR_OUT <= src_addr;
                  src_addr <= src_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
                  state <= ST_WAIT;
               end
            end
            default: begin
               state <= ST_IDLE;
               BUSY_OUT <= 1'b0;
               MEM_RD_OUT <= 1'b0;
               MEM_WR_OUT <= 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// file: verification/ccu_props.sv
// Port checker of the code conversion unit.
`timescale 1ns/1ns
`default_nettype none

module ccu_props (
   input wire logic SYS_CLK_IN,
   input wire logic SRST_IN,
   input wire logic CE_IN,
   input wire logic START_IN,
   input wire logic [1:0] OP_IN,
   input wire logic [31:0] ACC_IN,
   input wire logic [31:0] STACK1_IN,
   input wire logic [31:0] ACC_OUT,
   input wire logic DONE_OUT,
   input wire logic BUSY_OUT,
   input wire logic MEM_RD_OUT,
   input wire logic MEM_WR_OUT,
   input wire logic [15:0] MEM_WDATA_OUT
);
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (SRST_IN);

   // A command is taken only while idle and enabled.
   wire logic take;
   assign take = CE_IN && START_IN && !BUSY_OUT;

   function automatic logic ok_chr(input logic [7:0] c);
      return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
   endfunction

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   sequence s_rd;
      MEM_RD_OUT && CE_IN;
   endsequence
   sequence s_wr_pair;
      !MEM_RD_OUT ##1 MEM_WR_OUT [*2] ##1 !MEM_WR_OUT;
   endsequence
   property p_step;
      take && OP_IN != 2'h0 |=> DONE_OUT;
   endproperty
   property p_seg_top;
      take && OP_IN == 2'h1 |=> (ACC_OUT & 32'h8080_8080) == 32'h0;
   endproperty
   property p_gray_up;
      take && OP_IN == 2'h2 |=> ACC_OUT[31:16] == 16'h0000;
   endproperty
   property p_gray_full;
      take && OP_IN == 2'h2 && ACC_IN[15:0] == 16'h0200
         |=> ACC_OUT == 32'h0000_1023;
   endproperty
   property p_ord_zero;
      take && OP_IN == 2'h3 && ACC_IN == 32'h0 |=> ACC_OUT == 32'h0;
   endproperty
   property p_ord_ident;
      take && OP_IN == 2'h3 && ACC_IN == 32'h8765_4321
         |=> ACC_OUT == $past(STACK1_IN);
   endproperty
   property p_rd_wr;
      s_rd |=> s_wr_pair;
   endproperty
   property p_chr;
      MEM_WR_OUT |-> ok_chr(MEM_WDATA_OUT[15:8]) && ok_chr(MEM_WDATA_OUT[7:0]);
   endproperty
   property p_busy;
      take && OP_IN == 2'h0 && STACK1_IN[15:0] != 16'h0000 |=> BUSY_OUT;
   endproperty
   property p_mem_busy;
      MEM_RD_OUT || MEM_WR_OUT |-> BUSY_OUT;
   endproperty

   a_step: assert property (p_step) else $error("no done after op");
   a_seg_top: assert property (p_seg_top) else $error("seg top bit");
   a_gray_up: assert property (p_gray_up) else $error("gray upper");
   a_gray_full: assert property (p_gray_full)
      else $error("gray 1023");
   a_ord_zero: assert property (p_ord_zero)
      else $error("order zero");
   a_ord_ident: assert property (p_ord_ident)
      else $error("identity");
   a_rd_wr: assert property (p_rd_wr) else $error("read write pair");
   a_chr: assert property (p_chr) else $error("bad character");
   a_busy: assert property (p_busy) else $error("walk not busy");
   a_mem_busy: assert property (p_mem_busy)
      else $error("memory strobe while idle");
endmodule

bind ccu_top ccu_props u_props (.SYS_CLK_IN(SYS_CLK_IN), .SRST_IN(SRST_IN),
   .CE_IN(CE_IN), .START_IN(START_IN), .OP_IN(OP_IN), .ACC_IN(ACC_IN),
   .STACK1_IN(STACK1_IN), .ACC_OUT(ACC_OUT), .DONE_OUT(DONE_OUT),
   .BUSY_OUT(BUSY_OUT), .MEM_RD_OUT(MEM_RD_OUT), .MEM_WR_OUT(MEM_WR_OUT),
   .MEM_WDATA_OUT(MEM_WDATA_OUT));

`default_nettype wire

// file: verification/code_conversion_unit_tb_top.sv
// Self-checking testbench of the code conversion unit.
`timescale 1ns/1ns
`default_nettype none

module code_conversion_unit_tb_top;
   logic clk = 1'b0, srst = 1'b1, start = 1'b0, done, busy, rd, wr;
   logic ce = 1'b1;
   logic [1:0] op = 2'h0;
   logic [31:0] acc = 32'h0, stk = 32'h0, acc_o;
   logic [15:0] dest = 16'h0, rdata = 16'h0, addr, wdata;
   logic [15:0] mem [0:63];
   logic [6:0] seg_t [0:15] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D,
      7'h7D, 7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
   int num_errors = 0, cmp_count = 0;

   always #4 clk = ~clk;

   ccu_top dut (.SYS_CLK_IN(clk), .SRST_IN(srst), .CE_IN(ce),
      .START_IN(start), .OP_IN(op), .ACC_IN(acc), .STACK1_IN(stk),
      .DEST_IN(dest), .MEM_RDATA_IN(rdata), .ACC_OUT(acc_o),
      .DONE_OUT(done), .BUSY_OUT(busy), .MEM_RD_OUT(rd), .MEM_WR_OUT(wr),
      .MEM_ADDR_OUT(addr), .MEM_WDATA_OUT(wdata));

   // Word memory with one cycle of read latency.
   always @(posedge clk) begin
      if (wr) mem[addr[5:0]] <= wdata;
      if (rd) rdata <= mem[addr[5:0]];
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Issue one command and wait, bounded, for its completion pulse.
   task automatic run(input logic [1:0] o, input logic [31:0] a, s);
      int n;
      n = 0;
      @(posedge clk);
      op <= o;
      acc <= a;
      stk <= s;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      #1;
      while (done !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 100) begin
         num_errors++;
         $display("[ERR] %0t no completion", $time);
      end
   endtask

   function automatic logic [31:0] shuf(input logic [31:0] s, o);
      logic [31:0] r;
      logic [3:0] k;
      r = 32'h0;
      for (int i = 0; i < 8; i++) begin
         k = o[4*i +: 4];
         if (k >= 4'h1 && k <= 4'h8) r[4*(k-1) +: 4] = s[4*i +: 4];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_seg();
      logic [31:0] e;
      for (int j = 0; j < 4; j++) begin
         e = {1'b0, seg_t[4*j+3], 1'b0, seg_t[4*j+2],
            1'b0, seg_t[4*j+1], 1'b0, seg_t[4*j]};
         run(2'h1, {16'hFFFF, 16'(16'h3210 + 16'h4444 * j)}, 32'h0);
         check(acc_o, e);
      end
      $display("segment test over");
   endtask

   // Upper accumulator bits are set so that clearing them is visible.
   // A 360 or 720 count encoder starts its code at an offset, which the
   // program takes off the decimal result afterwards.
   task automatic t_gray();
      int vals [6] = '{0, 359, 511, 1023, 435, 871};
      int offs [6] = '{0, 0, 0, 0, 76, 152};
      logic [15:0] b;
      int d;
      for (int j = 0; j < 6; j++) begin
         b = 16'(vals[j]);
         run(2'h2, {16'hFFFF, b ^ (b >> 1)}, 32'h0);
         check(acc_o, {16'h0, 4'(b / 1000), 4'(b / 100 % 10),
            4'(b / 10 % 10), 4'(b % 10)});
         d = acc_o[15:12] * 1000 + acc_o[11:8] * 100 + acc_o[7:4] * 10
            + acc_o[3:0];
         check(32'(d - offs[j]), 32'(vals[j] - offs[j]));
      end
      $display("gray test over");
   endtask

   task automatic t_shuf();
      logic [31:0] ords [5] = '{32'h8765_4321, 32'h1234_5678,
         32'h09F0_1A2B, 32'h1111_2222, 32'h0};
      for (int j = 0; j < 5; j++) begin
         run(2'h3, ords[j], 32'hFEDC_5678 + j);
         check(acc_o, shuf(32'hFEDC_5678 + j, ords[j]));
         if (j == 2) begin
            check(acc_o, 32'h0000_0075);
         end
         if (j == 3) begin
            check(acc_o, 32'h0000_005F);
         end
      end
      $display("shuffle test over");
   endtask

   // A start seen while the enable is low must leave everything frozen.
   task automatic t_ce();
      logic [31:0] held;
      held = acc_o;
      @(posedge clk);
      ce <= 1'b0;
      op <= 2'h1;
      acc <= 32'h0000_1234;
      start <= 1'b1;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      start <= 1'b0;
      #1;
      check({31'h0, done}, 32'h0);
      check(acc_o, held);
      $display("enable test over");
   endtask

   task automatic t_hta();
      mem[16] = 16'h09AF;
      mem[17] = 16'h1B2C;
      @(posedge clk);
      dest <= 16'h0020;
      run(2'h0, 32'h0000_0010, 32'h0000_0002);
      check({16'h0, mem[32]}, 32'h3039);
      check({16'h0, mem[33]}, 32'h4146);
      check({16'h0, mem[34]}, 32'h3142);
      check({16'h0, mem[35]}, 32'h3243);
      check({31'h0, busy}, 32'h0);
      run(2'h0, 32'hA5A5_0010, 32'h0);
      check(acc_o, 32'hA5A5_0010);
      $display("table test over");
   endtask

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_seg();
      t_gray();
      t_shuf();
      t_ce();
      t_hta();
      report_and_stop();
   end

   // Watchdog well beyond the fewer than one hundred cycles the tests need.
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
endmodule

`default_nettype wire
